/* rtl/secl_pkg.sv */
// secl_pkg: constants, opcodes, status layout and pin carrier for the
// serial eeprom command logic.
// assumes a 200 MHz mclk and a four-wire mode-0 serial master outside.
package secl_pkg;

    // clock and programming time
    localparam int CLK_PERIOD_NS = 5;
    localparam int PROG_TIME_MS  = 10;
    localparam int PROG_CYCLES   = (PROG_TIME_MS * 1_000_000) / CLK_PERIOD_NS;

    // array geometry
    localparam int ADDR_W      = 9;
    localparam int ARRAY_DEPTH = 512;
    localparam int PAGE_BYTES  = 4;
    localparam int FIFO_DEPTH  = 2;

    // opcodes; bit 3 is don't-care (or the ninth address bit)
    localparam logic [7:0] OPC_CARE_MASK      = 8'hf7;
    localparam logic [7:0] ENABLE_WRITES_CMD  = 8'h06;
    localparam logic [7:0] DISABLE_WRITES_CMD = 8'h04;
    localparam logic [7:0] STATUS_READ_CMD    = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD   = 8'h01;
    localparam logic [7:0] ARRAY_READ_CMD     = 8'h03;
    localparam logic [7:0] ARRAY_WRITE_CMD    = 8'h02;
    localparam int         OPC_A8_BIT         = 3;

    // status byte layout
    localparam logic [3:0] STAT_FILL          = 4'hf;
    localparam logic [7:0] STAT_BUSY_VALUE    = 8'hff;
    localparam int         STAT_GUARD_LO_BIT  = 2;
    localparam int         STAT_GUARD_HI_BIT  = 3;
    localparam logic [1:0] GUARD_RESET        = 2'h0;
    localparam logic [7:0] IDLE_READ_BYTE     = 8'hff;

    // lowest guarded address per level
    localparam logic [8:0] GUARD_L1_BASE = 9'h180;
    localparam logic [8:0] GUARD_L2_BASE = 9'h100;

    // serial pins after synchronisation
    typedef struct packed {
        logic wp_n;
        logic hold_n;
        logic cs_n;
        logic sck;
        logic si;
    } secl_pins_t;

    localparam secl_pins_t PINS_RESET = 5'h1c;

    typedef enum logic [7:0] {
        PH_IDLE = 8'h01,
        PH_OPC  = 8'h02,
        PH_ADDR = 8'h04,
        PH_ARD  = 8'h08,
        PH_AWR  = 8'h10,
        PH_SRD  = 8'h20,
        PH_SWR  = 8'h40,
        PH_DEAD = 8'h80
    } secl_phase_t;

endpackage

/* rtl/secl_sync.sv */
// secl_sync: three-stage synchroniser with agreement filter.
// assumes inputs are asynchronous to mclk; q moves only once stages two
// and three agree, so a single-cycle glitch between them is dropped.
`timescale 1ns/1ps
`default_nettype none
module secl_sync
#(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
)
(
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // async in, filtered out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } secl_sync_t;

    secl_sync_t s;
    secl_sync_t next_s;

    always_comb
    begin
        next_s    = s;
        next_s.s1 = d;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        for (int i = 0; i < W; i++)
        begin
            if (s.s2[i] == s.s3[i])
            begin
                next_s.q[i] = s.s3[i];
            end
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            s <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign q = s.q;
endmodule
`default_nettype wire

/* rtl/secl_core.sv */
// secl_core: command, protection and array logic of a 512-byte serial
// eeprom slave, sampling all link pins with mclk.
// assumes a mode-0 master with sck at most mclk/16; so needs an
// external tri-state buffer driven from so_o and so_oe.
//
// Functional notes
// RQ1: pause low while selected suspends the transfer without resetting it.
// RQ2: master changes the pause pin only while sck is low.
// RQ3: during pause, output is released and sck and si are ignored.
// RQ4: opcode 0000x110 sets write enable, 0000x100 clears it.
// RQ5: opcode 0000x101 reads status, 0000x001 writes status.
// RQ6: opcode 0000a011 reads array, 0000a010 writes; a is address bit 8.
// RQ7: invalid opcode: nothing shifted in, output released until next select.
// RQ8: read sends opcode then low address byte; addressed byte shifts out.
// RQ9: reading continues with auto-increment, wrapping 1ff to 000.
// RQ10: status is 1111, guard hi, guard lo, write enable, busy.
// RQ11: status read while busy returns busy bit and all other bits one.
// RQ12: guard levels protect nothing, 180-1ff, 100-1ff, 000-1ff.
// RQ13: write enable is clear after reset.
// RQ14: enable-writes only works while the protect pin is high.
// RQ15: disable-writes or protect pin low clears write enable.
// RQ16: finishing an array or status write clears write enable.
// RQ17: programming starts at chip-select rise right after a whole byte.
// RQ18: array write to a guarded address is not programmed.
// RQ19: while busy only the status read command is accepted.
// RQ20: page write increments two low address bits; extra bytes overwrite.
// RQ21: write with protect low or enable clear is ignored until deselect.
// RQ22: status write byte carries guard bits in positions 3 and 2.
// RQ23: selected only while chip select low; otherwise output released.
// RQ24: every byte travels most significant bit first.
// RQ25: link runs clock phase 0, polarity 0.
// RQ26: si sampled on sck rise, so updated after sck fall.
`timescale 1ns/1ps
`default_nettype none
module secl_core
    import secl_pkg::*;
#(
    parameter int PROG_LEN   = PROG_CYCLES,
    parameter int PAGE_LEN   = PAGE_BYTES,
    parameter int FIFO_LEN   = FIFO_DEPTH
)
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // serial link pins
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic si,
    input  wire logic hold_n,
    input  wire logic wp_n,
    // serial output and its enable
    output logic      so_o,
    output logic      so_oe
);
    localparam int PCW = $clog2(PROG_LEN + 1);
    localparam int FPW = (FIFO_LEN > 1) ? $clog2(FIFO_LEN) : 1;
    localparam int FCW = $clog2(FIFO_LEN + 1);
    localparam int PGW = $clog2(PAGE_LEN);

    typedef struct packed {
        secl_phase_t                    phase;
        logic                           sck_q;
        logic                           cs_q;
        logic [2:0]                     bit_cnt;
        logic [7:0]                     rx;
        logic                           is_write;
        logic [ADDR_W-1:0]              addr;
        logic                           wel;
        logic [1:0]                     guard;
        logic [1:0]                     new_guard;
        logic                           busy;
        logic                           prog_array;
        logic [PCW-1:0]                 prog_cnt;
        logic [PAGE_LEN-1:0][7:0]       page;
        logic [PAGE_LEN-1:0]            page_mask;
        logic                           drive;
        logic [7:0]                     tx;
        logic                           so;
        logic                           so_oe;
        logic [FIFO_LEN-1:0][7:0]       fifo;
        logic [FPW-1:0]                 wptr;
        logic [FPW-1:0]                 rptr;
        logic [FCW-1:0]                 fcount;
    } secl_core_t;

    secl_core_t s;
    secl_core_t next_s;
    secl_pins_t p;
    secl_pins_t raw;

    logic [7:0] mem [ARRAY_DEPTH];
    logic [7:0] rd_byte;
    logic       mem_we;

    assign raw = {wp_n, hold_n, cs_n, sck, si};

    secl_sync #(
        .W       (5),
        .RST_VAL (PINS_RESET)
    ) u_sync (
        .mclk (mclk),
        .rst  (rst),
        .d    (raw),
        .q    (p)
    );

    function automatic logic guarded(input logic [1:0] lvl, input logic [ADDR_W-1:0] a);
        logic hit;
        hit = 1'b0;
        case (lvl)
            2'h1:    hit = (a >= GUARD_L1_BASE);
            2'h2:    hit = (a >= GUARD_L2_BASE);
            2'h3:    hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    function automatic logic [FPW-1:0] ptr_inc(input logic [FPW-1:0] ptr);
        logic [FPW-1:0] r;
        r = (ptr == FPW'(FIFO_LEN - 1)) ? '0 : FPW'(ptr + 1'b1);
        return r;
    endfunction

    assign rd_byte = mem[s.addr];

    always_comb
    begin
        logic       active;
        logic       rise;
        logic       fall;
        logic       cs_fall;
        logic       cs_rise;
        logic       push;
        logic       pop;
        logic [7:0] rx_next;
        logic [7:0] op;
        logic [7:0] ld;
        active  = 1'b0;
        rise    = 1'b0;
        fall    = 1'b0;
        cs_fall = 1'b0;
        cs_rise = 1'b0;
        push    = 1'b0;
        pop     = 1'b0;
        rx_next = 8'h00;
        op      = 8'h00;
        ld      = 8'h00;
        mem_we  = 1'b0;
        next_s  = s;

        // edges are taken only while selected and not paused
        active       = ~p.cs_n & p.hold_n;                      // [RQ1] [RQ3] [RQ23]
        rise         = active & p.sck & ~s.sck_q;               // [RQ25]
        fall         = active & ~p.sck & s.sck_q;
        cs_fall      = ~p.cs_n & s.cs_q;
        cs_rise      = p.cs_n & ~s.cs_q;
        next_s.sck_q = p.sck;
        next_s.cs_q  = p.cs_n;
        rx_next      = {s.rx[6:0], p.si};                       // [RQ24]
        op           = rx_next & OPC_CARE_MASK;

        // self-timed programming cycle
        if (s.busy)
        begin
            if (s.prog_cnt == '0)
            begin
                next_s.busy = 1'b0;
                next_s.wel  = 1'b0;                             // [RQ16]
                mem_we      = s.prog_array;
                if (!s.prog_array)
                begin
                    next_s.guard = s.new_guard;
                end
            end
            else
            begin
                next_s.prog_cnt = PCW'(s.prog_cnt - 1'b1);
            end
        end

        // read-ahead into the buffer; a full buffer stalls the fetch
        push = (s.phase == PH_ARD) && (s.fcount < FCW'(FIFO_LEN));
        if (push)
        begin
            next_s.fifo[s.wptr] = rd_byte;
            next_s.wptr         = ptr_inc(s.wptr);
            next_s.addr         = ADDR_W'(s.addr + 1'b1);       // [RQ9]
        end

        // sample si on sck rise
        if (rise)                                               // [RQ26]
        begin
            next_s.bit_cnt = 3'(s.bit_cnt + 1'b1);
            if (s.phase != PH_DEAD)
            begin
                next_s.rx = rx_next;                            // [RQ7]
            end
            if (s.bit_cnt == 3'h7)
            begin
                case (s.phase)
                    PH_OPC:
                    begin
                        next_s.phase = PH_DEAD;                 // [RQ7]
                        if (s.busy && op != STATUS_READ_CMD)
                        begin
                            next_s.phase = PH_DEAD;             // [RQ19]
                        end
                        else if (op == ENABLE_WRITES_CMD)
                        begin
                            if (p.wp_n)
                            begin
                                next_s.wel = 1'b1;              // [RQ4] [RQ14]
                            end
                        end
                        else if (op == DISABLE_WRITES_CMD)
                        begin
                            next_s.wel = 1'b0;                  // [RQ4] [RQ15]
                        end
                        else if (op == STATUS_READ_CMD)
                        begin
                            next_s.phase = PH_SRD;              // [RQ5]
                        end
                        else if (op == STATUS_WRITE_CMD)
                        begin
                            next_s.page_mask = '0;
                            if (p.wp_n && s.wel)
                            begin
                                next_s.phase = PH_SWR;          // [RQ5]
                            end
                        end
                        else if (op == ARRAY_READ_CMD || op == ARRAY_WRITE_CMD)
                        begin
                            next_s.phase    = PH_ADDR;          // [RQ6]
                            next_s.is_write = (op == ARRAY_WRITE_CMD);
                            next_s.addr     = {rx_next[OPC_A8_BIT], 8'h00};
                        end
                    end
                    PH_ADDR:
                    begin
                        next_s.addr = {s.addr[ADDR_W-1], rx_next};     // [RQ8]
                        if (s.is_write)
                        begin
                            next_s.page_mask = '0;
                            next_s.phase     = (p.wp_n && s.wel) ? PH_AWR : PH_DEAD; // [RQ21]
                        end
                        else
                        begin
                            next_s.phase  = PH_ARD;
                            next_s.wptr   = '0;
                            next_s.rptr   = '0;
                            next_s.fcount = '0;
                        end
                    end
                    PH_AWR:
                    begin
                        // only the low address bits move inside the page
                        next_s.page[s.addr[PGW-1:0]]      = rx_next;     // [RQ20]
                        next_s.page_mask[s.addr[PGW-1:0]] = 1'b1;
                        next_s.addr[PGW-1:0] = PGW'(s.addr[PGW-1:0] + 1'b1); // [RQ20]
                    end
                    PH_SWR:
                    begin
                        next_s.new_guard    = {rx_next[STAT_GUARD_HI_BIT],
                                               rx_next[STAT_GUARD_LO_BIT]}; // [RQ22]
                        next_s.page_mask[0] = 1'b1;
                    end
                    default:
                    begin
                        next_s.phase = s.phase;
                    end
                endcase
            end
        end

        // update so after sck fall, msb first
        if (fall && (s.phase == PH_ARD || s.phase == PH_SRD))   // [RQ26]
        begin
            if (s.bit_cnt == 3'h0)
            begin
                if (s.phase == PH_SRD)
                begin
                    ld = s.busy ? STAT_BUSY_VALUE                       // [RQ11]
                                : {STAT_FILL, s.guard, s.wel, 1'b0};    // [RQ10]
                end
                else if (s.fcount != '0)
                begin
                    ld  = s.fifo[s.rptr];                       // [RQ8]
                    pop = 1'b1;
                end
                else
                begin
                    ld = IDLE_READ_BYTE;
                end
                next_s.so    = ld[7];                           // [RQ24]
                next_s.tx    = {ld[6:0], 1'b0};
                next_s.drive = 1'b1;
            end
            else
            begin
                next_s.so = s.tx[7];
                next_s.tx = {s.tx[6:0], 1'b0};
            end
        end

        if (pop)
        begin
            next_s.rptr = ptr_inc(s.rptr);
        end
        if (push && !pop)
        begin
            next_s.fcount = FCW'(s.fcount + 1'b1);
        end
        else if (pop && !push)
        begin
            next_s.fcount = FCW'(s.fcount - 1'b1);
        end

        // new selection restarts the sequence
        if (cs_fall)
        begin
            next_s.phase   = PH_OPC;
            next_s.bit_cnt = 3'h0;
            next_s.drive   = 1'b0;
            next_s.fcount  = '0;
            next_s.wptr    = '0;
            next_s.rptr    = '0;
        end

        // deselect: programming starts only after a whole byte
        if (cs_rise)
        begin
            if (!s.busy && s.bit_cnt == 3'h0 && p.wp_n && s.wel)   // [RQ17]
            begin
                if (s.phase == PH_AWR && s.page_mask != '0
                    && !guarded(s.guard, s.addr))               // [RQ18] [RQ12]
                begin
                    next_s.busy       = 1'b1;
                    next_s.prog_array = 1'b1;
                    next_s.prog_cnt   = PCW'(PROG_LEN - 1);
                end
                else if (s.phase == PH_SWR && s.page_mask[0])   // [RQ22]
                begin
                    next_s.busy       = 1'b1;
                    next_s.prog_array = 1'b0;
                    next_s.prog_cnt   = PCW'(PROG_LEN - 1);
                end
            end
            next_s.phase = PH_IDLE;                             // [RQ21]
            next_s.drive = 1'b0;
        end

        // protect pin low always drops write enable
        if (!p.wp_n)
        begin
            next_s.wel = 1'b0;                                  // [RQ15]
        end

        // output released when deselected, paused or not answering
        next_s.so_oe = next_s.drive & ~p.cs_n & p.hold_n;       // [RQ3] [RQ7] [RQ23]
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            s       <= '0;
            s.phase <= PH_IDLE;
            s.sck_q <= 1'b0;
            s.cs_q  <= 1'b1;
            s.wel   <= 1'b0;                                    // [RQ13]
            s.guard <= GUARD_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    // the page lands on its own 4-byte block; unsent bytes keep old data
    always_ff @(posedge mclk)
    begin
        if (mem_we)
        begin
            for (int i = 0; i < PAGE_LEN; i++)
            begin
                if (s.page_mask[i])
                begin
                    mem[{s.addr[ADDR_W-1:PGW], PGW'(i)}] <= s.page[i];  // [RQ20]
                end
            end
        end
    end

    assign so_o  = s.so;
    assign so_oe = s.so_oe;
endmodule
`default_nettype wire

/* bench/secl_core_props.sv */
// secl_core_props: pin-level checks of the serial output of secl_core.
// assumes a mode-0 master whose sck half periods last 8 mclk.
`timescale 1ns/1ps
`default_nettype none
module secl_core_props
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // link pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic so_o,
    input wire logic so_oe
);
    logic [3:0] fall_age;
    logic [3:0] cs_age;
    logic [3:0] hfall_age;
    logic [3:0] hrise_age;
    logic [3:0] rises;
    // ages saturate at 15: anything older is long ago at this link rate
    function automatic logic [3:0] age(input logic ev, input logic [3:0] a);
        return ev ? 4'h0 : a + {3'h0, a != 4'hf};
    endfunction
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            fall_age  <= 4'hf;
            cs_age    <= 4'hf;
            hfall_age <= 4'hf;
            hrise_age <= 4'hf;
            rises     <= 4'h0;
        end
        else
        begin
            fall_age  <= age($fell(sck), fall_age);
            cs_age    <= age($rose(cs_n), cs_age);
            hfall_age <= age($fell(hold_n), hfall_age);
            hrise_age <= age($rose(hold_n), hrise_age);
            rises     <= cs_n ? 4'h0 : rises + {3'h0, $rose(sck) && hold_n && rises != 4'hf};
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_deselected; cs_n [*8]; endsequence
    sequence s_paused; !hold_n [*8]; endsequence
    a_deselect_quiet: assert property (s_deselected |-> !so_oe)
        else $error("output enabled while deselected");
    a_deselect_release: assert property ($rose(cs_n) |-> ##[1:8] !so_oe)
        else $error("output not released after deselect");
    a_pause_quiet: assert property (s_paused |-> !so_oe)
        else $error("output enabled during pause");
    a_pause_release: assert property ($fell(hold_n) && !cs_n |-> ##[1:8] !so_oe)
        else $error("output not released at pause");
    a_opcode_silent: assert property (so_oe && !cs_n |-> rises >= 4'h8)
        else $error("output enabled before a whole opcode");
    a_so_after_fall: assert property (
        so_oe && $past(so_oe) && $changed(so_o) |-> fall_age <= 4'h8)
        else $error("output moved away from an sck fall");
    a_oe_rise_cause: assert property (
        $rose(so_oe) |-> fall_age <= 4'h8 || hrise_age <= 4'h8)
        else $error("output enabled without a cause");
    a_oe_fall_cause: assert property (
        $fell(so_oe) |-> cs_age <= 4'h8 || hfall_age <= 4'h8)
        else $error("read output stopped while selected");
endmodule
bind secl_core secl_core_props u_props (.mclk(mclk), .rst(rst), .cs_n(cs_n), .sck(sck),
    .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_o(so_o), .so_oe(so_oe));
`default_nettype wire

/* bench/secl_master.sv */
// secl_master: mode-0 serial master driving the link pins of secl_core.
// assumes mclk at 200 MHz; sck half period is 8 mclk, so 80 ns per bit.
`timescale 1ns/1ps
`default_nettype none
module secl_master
(
    // clock
    input  wire logic mclk,
    // link pins
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    output logic      hold_n,
    input  wire logic so_o,
    input  wire logic so_oe
);
    initial
    begin
        cs_n   = 1'b1;
        sck    = 1'b0;
        si     = 1'b1;
        hold_n = 1'b1;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // msb first, si moves while sck low; a released output reads as x
    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nbits; i--)
        begin
            si <= tx[i];
            wait_clk(8);
            sck <= 1'b1;
            rx[i] = so_oe ? so_o : 1'bx;
            wait_clk(8);
            sck <= 1'b0;
        end
    endtask
    task automatic select();
        cs_n <= 1'b0;
        wait_clk(8);
    endtask
    // cs rises inside the sck low time after the last bit
    task automatic deselect();
        wait_clk(4);
        cs_n <= 1'b1;
        wait_clk(56);
    endtask
    // pause with sck low, cs kept low; sck and si toggle meanwhile
    task automatic pause(input int n);
        wait_clk(4);
        hold_n <= 1'b0;
        for (int k = 0; k < 2 * n; k++)
        begin
            wait_clk(8);
            sck <= ~sck;
            si <= ~si;
        end
        wait_clk(8);
        hold_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

/* bench/serial_eeprom_command_logic_tb.sv */
// serial_eeprom_command_logic_tb: self-checking bench of secl_core.
// assumes secl_master on the link and a short programming time.
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_command_logic_tb
    import secl_pkg::*;
;
    localparam int PROG = 1000;
    logic mclk;
    logic rst;
    logic wp_n;
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic so_o;
    logic so_oe;
    int   errors = 0;
    int   num_checks = 0;
    secl_core #(.PROG_LEN(PROG), .PAGE_LEN(PAGE_BYTES), .FIFO_LEN(FIFO_DEPTH)) uut (
        .mclk(mclk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
        .wp_n(wp_n), .so_o(so_o), .so_oe(so_oe));
    secl_master m (.mclk(mclk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
        .so_o(so_o), .so_oe(so_oe));
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] op);
        logic [7:0] r;
        m.select();
        m.xfer(op, 8, r);
        m.deselect();
    endtask
    task automatic status_is(input logic [7:0] exp);
        logic [7:0] r;
        m.select();
        m.xfer(STATUS_READ_CMD, 8, r);
        m.xfer(8'h00, 8, r);
        m.deselect();
        check8(r, exp);
    endtask
    task automatic wait_done();
        m.wait_clk(PROG + 64);
    endtask
    task automatic array_write(input logic [8:0] a, input logic [39:0] d, input int n,
                               input logic en);
        logic [7:0] r;
        if (en)
            cmd(ENABLE_WRITES_CMD);
        m.select();
        m.xfer(ARRAY_WRITE_CMD | {4'h0, a[8], 3'h0}, 8, r);
        m.xfer(a[7:0], 8, r);
        for (int k = 0; k < n; k++)
            m.xfer(d[39 - 8 * k -: 8], 8, r);
        m.deselect();
    endtask
    task automatic array_read(input logic [8:0] a, input logic [31:0] exp, input int n);
        logic [7:0] r;
        m.select();
        m.xfer(ARRAY_READ_CMD | {4'h0, a[8], 3'h0}, 8, r);
        m.xfer(a[7:0], 8, r);
        for (int k = 0; k < n; k++)
        begin
            m.xfer(8'h00, 8, r);
            check8(r, exp[31 - 8 * k -: 8]);
        end
        m.deselect();
    endtask
    task automatic t_latch();
        status_is(8'hf0);
        wp_n <= 1'b0;
        cmd(8'h0e);
        status_is(8'hf0);
        wp_n <= 1'b1;
        cmd(8'h0e);
        status_is(8'hf2);
        cmd(8'h0c);
        status_is(8'hf0);
        cmd(ENABLE_WRITES_CMD);
        wp_n <= 1'b0;
        m.wait_clk(16);
        wp_n <= 1'b1;
        status_is(8'hf0);
    endtask
    task automatic t_page();
        array_write(9'h1fe, 40'hc0c1c2c3c4, 5, 1'b1);
        status_is(8'hff);
        array_read(9'h000, 32'hxxxxxxxx, 1);
        wait_done();
        status_is(8'hf0);
        array_write(9'h000, 40'h5a00000000, 1, 1'b1);
        wait_done();
        array_read(9'h1fc, 32'hc2c3c4c1, 4);
        array_read(9'h1fe, 32'hc4c15a00, 3);
    endtask
    task automatic t_refused();
        logic [7:0] r;
        array_write(9'h010, 40'h11, 1, 1'b0);
        status_is(8'hf0);
        cmd(ENABLE_WRITES_CMD);
        m.select();
        m.xfer(ARRAY_WRITE_CMD, 8, r);
        m.xfer(8'h20, 8, r);
        m.xfer(8'h77, 4, r);
        m.deselect();
        status_is(8'hf2);
        cmd(DISABLE_WRITES_CMD);
        m.select();
        m.xfer(8'h83, 8, r);
        m.xfer(8'h00, 8, r);
        m.xfer(8'h00, 8, r);
        m.deselect();
        check8(r, 8'hxx);
    endtask
    task automatic t_pause();
        logic [7:0] r;
        m.select();
        m.xfer(ARRAY_READ_CMD | 8'h08, 8, r);
        m.xfer(8'hfc, 8, r);
        m.xfer(8'h00, 8, r);
        check8(r, 8'hc2);
        m.pause(2);
        m.xfer(8'h00, 8, r);
        check8(r, 8'hc3);
        m.deselect();
    endtask
    // level 1 guards from 180, level 2 from 100, level 3 everything
    task automatic t_guard();
        logic [7:0] r;
        logic [8:0] addrs [4];
        logic       hit;
        addrs = '{9'h0fc, 9'h100, 9'h17c, 9'h180};
        for (int lv = 0; lv < 4; lv++)
        begin
            cmd(ENABLE_WRITES_CMD);
            m.select();
            m.xfer(STATUS_WRITE_CMD, 8, r);
            m.xfer({4'hf, lv[1:0], 2'h3}, 8, r);
            m.deselect();
            wait_done();
            status_is({4'hf, lv[1:0], 2'h0});
            for (int k = 0; k < 4; k++)
            begin
                hit = lv == 3 || (lv == 2 && addrs[k] >= 9'h100)
                      || (lv == 1 && addrs[k] >= 9'h180);
                array_write(addrs[k], 40'h0, 1, 1'b1);
                status_is(hit ? {4'hf, lv[1:0], 2'h2} : 8'hff);
                wait_done();
                cmd(DISABLE_WRITES_CMD);
            end
        end
    endtask
    initial
    begin
        rst = 1'b1;
        wp_n = 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        m.wait_clk(8);
        t_latch();
        t_page();
        t_refused();
        t_pause();
        t_guard();
        report_and_stop();
    end
    initial
    begin
        // the full run needs about 56000 cycles
        repeat (80000) @(posedge mclk);
        errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
